// ==== dv/gpt_pin_source.sv ====
// Pin source standing in for external gate, event, direction and capture signals
`timescale 1ns/100ps
module gpt_pin_source (
  // Clock
  input wire logic i_clk_sys,
  // Pin levels
  output logic [2:0] o_timer_pin_input,
  output logic [2:0] o_direction_pin_input,
  output logic o_capture_pin_input
);
  initial begin
    o_timer_pin_input = 3'h0;
    o_direction_pin_input = 3'h0;
    o_capture_pin_input = 1'b0;
  end

  // Index 3 selects the capture pin
  task automatic drive(input int idx, input logic lvl);
    @(posedge i_clk_sys);
    if (idx == 3) begin
      o_capture_pin_input <= lvl;
    end else begin
      o_timer_pin_input[idx] <= lvl;
    end
  endtask

  // Width and gap in clocks make a prompt or a slow source
  task automatic pulse(input int idx, input int hi, input int lo);
    drive(idx, 1'b1);
    repeat (hi - 1) @(posedge i_clk_sys);
    drive(idx, 1'b0);
    repeat (lo - 1) @(posedge i_clk_sys);
  endtask

  task automatic set_dir(input int idx, input logic lvl);
    @(posedge i_clk_sys);
    o_direction_pin_input[idx] <= lvl;
  endtask
endmodule

// ==== dv/tb_top.sv ====
// Self-checking bench for the two general purpose timer groups
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected at %0t: got %h want %h", $time, (g), (e)); end end
module tb_top;
  import gpt_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} row_t;
  logic clk_sys, reset_n, psel, penable, pwrite, pready, pslverr, cpin, tgl, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [2:0] tpin, dpin;
  logic [gpt_pkg::NUM_IRQ-1:0] irq;
  int n_fail, checks_done, cyc, hi_cnt;
  row_t rows[15] = '{
    '{8'h00, 32'h0000_1034, 32'h0000_1034, 1'b0},
    '{8'h04, 32'h0000_1E1F, 32'h0000_1E1F, 1'b0},
    '{8'h08, 32'h0000_15A6, 32'h0000_15A6, 1'b0},
    '{8'h10, 32'hFFFF_0001, 32'h0000_0001, 1'b0},
    '{8'h14, 32'h0000_8001, 32'h0000_8001, 1'b0},
    '{8'h18, 32'h0000_5A5A, 32'h0000_5A5A, 1'b0},
    '{8'h20, 32'h0000_01C5, 32'h0000_01C5, 1'b0},
    '{8'h24, 32'h0000_013A, 32'h0000_013A, 1'b0},
    '{8'h28, 32'h0000_1357, 32'h0000_1357, 1'b0},
    '{8'h2C, 32'h0000_2468, 32'h0000_2468, 1'b0},
    '{8'h30, 32'h0000_A5A5, 32'h0000_A5A5, 1'b0},
    '{8'h34, 32'h0000_003F, 32'h0000_0000, 1'b0},
    '{8'h38, 32'h0000_003F, 32'h0000_003F, 1'b0},
    '{8'h3C, 32'h00FE_DCBA, 32'h00FE_DCBA, 1'b0},
    '{8'h40, 32'h0000_FFFF, 32'h0000_0000, 1'b1}
  };

  gpt_units i_dut (
    .i_clk_sys(clk_sys), .i_reset_n(reset_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_timer_pin_input(tpin),
    .i_direction_pin_input(dpin), .i_capture_pin_input(cpin),
    .o_toggle_pin_output(tgl), .o_irq_req(irq)
  );

  gpt_pin_source i_pins (
    .i_clk_sys(clk_sys), .o_timer_pin_input(tpin), .o_direction_pin_input(dpin),
    .o_capture_pin_input(cpin)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  // One APB transfer; read data and error land in rdv and rerr
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rdv = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Run a timer for a fixed span and check the tick count
  task automatic measure(input logic [7:0] c, input logic [7:0] v, input logic [31:0] w,
                         input int lo, input int hi);
    apb(1'b1, v, 32'h0);
    apb(1'b1, c, w);
    repeat (800) @(posedge clk_sys);
    apb(1'b1, c, 32'h0);
    apb(1'b0, v, 32'h0);
    `CHK(rdv >= lo && rdv <= hi, 1'b1)
  endtask

  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (6) @(posedge clk_sys);
    `CHK({pready, pslverr, tgl, irq}, 9'h000)
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      `CHK(rerr, rows[i].e)
      apb(1'b0, rows[i].a, 32'h0);
      `CHK({rerr, rdv}, {rows[i].e, rows[i].x})
    end
    // Reset in mid-run clears every register
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      `CHK({rerr, rdv}, {(i == 3 || i == 7), 32'h0})
    end
    // Counter mode, pin direction, underflow and toggle latch
    apb(1'b1, 8'h04, 32'h0000_2002);
    repeat (5) i_pins.pulse(1, 2, 2);
    apb(1'b0, 8'h14, 32'h0);
    `CHK(rdv, 32'h0000_0005)
    apb(1'b1, 8'h04, 32'h0000_2012);
    i_pins.set_dir(1, 1'b1);
    repeat (2) i_pins.pulse(1, 2, 2);
    apb(1'b0, 8'h14, 32'h0);
    `CHK(rdv, 32'h0000_0003)
    apb(1'b1, 8'h04, 32'h0000_220A);
    repeat (4) i_pins.pulse(1, 2, 2);
    apb(1'b0, 8'h14, 32'h0);
    `CHK(rdv, 32'h0000_FFFF)
    apb(1'b0, 8'h04, 32'h0);
    `CHK(rdv[14], 1'b1)
    `CHK(tgl, 1'b1)
    apb(1'b1, 8'h38, 32'h0000_0002);
    repeat (3) @(posedge clk_sys);
    `CHK(irq, 6'h02)
    apb(1'b1, 8'h34, 32'h0000_0002);
    repeat (3) @(posedge clk_sys);
    `CHK(irq, 6'h00)
    // Prescaled timer mode in both groups
    measure(8'h04, 8'h14, 32'h0000_2000, 99, 102);
    measure(8'h04, 8'h14, 32'h0000_2400, 49, 51);
    measure(8'h20, 8'h28, 32'h0000_0200, 199, 203);
    // Gated timer mode
    apb(1'b1, 8'h14, 32'h0);
    apb(1'b1, 8'h04, 32'h0000_2005);
    repeat (200) @(posedge clk_sys);
    apb(1'b0, 8'h14, 32'h0);
    `CHK(rdv, 32'h0)
    i_pins.drive(1, 1'b1);
    repeat (200) @(posedge clk_sys);
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    `CHK(rdv inside {[24:27]}, 1'b1)
    i_pins.drive(1, 1'b0);
    // Capture into aux lo, reload from aux hi
    apb(1'b1, 8'h14, 32'h0000_1234);
    apb(1'b1, 8'h00, 32'h0000_2020);
    repeat (100) @(posedge clk_sys);
    apb(1'b0, 8'h10, 32'h0);
    `CHK(rdv, 32'h0)
    i_pins.pulse(0, 2, 2);
    apb(1'b0, 8'h10, 32'h0);
    `CHK(rdv, 32'h0000_1234)
    apb(1'b1, 8'h18, 32'h0000_0777);
    apb(1'b1, 8'h08, 32'h0000_20C0);
    i_pins.pulse(2, 2, 2);
    apb(1'b0, 8'h14, 32'h0);
    `CHK(rdv, 32'h0000_0777)
    apb(1'b0, 8'h18, 32'h0);
    `CHK(rdv, 32'h0000_0777)
    // Second group capture with clear, then wrap reload
    apb(1'b1, 8'h2C, 32'h0000_0042);
    apb(1'b1, 8'h24, 32'h0000_0020);
    i_pins.pulse(3, 2, 2);
    apb(1'b0, 8'h30, 32'h0);
    `CHK(rdv, 32'h0000_0042)
    apb(1'b0, 8'h2C, 32'h0);
    `CHK(rdv, 32'h0)
    apb(1'b0, 8'h34, 32'h0);
    `CHK(rdv[5], 1'b1)
    apb(1'b1, 8'h30, 32'h0000_FFF0);
    apb(1'b1, 8'h28, 32'h0000_FFFE);
    apb(1'b1, 8'h20, 32'h0000_0204);
    repeat (40) @(posedge clk_sys);
    apb(1'b1, 8'h20, 32'h0);
    apb(1'b0, 8'h28, 32'h0);
    `CHK(rdv inside {[32'h0000_FFF0:32'h0000_FFFF]}, 1'b1)
    apb(1'b0, 8'h20, 32'h0);
    `CHK(rdv[10], 1'b1)
    // Aux lo chained on core A toggle latch
    apb(1'b1, 8'h10, 32'h0);
    apb(1'b1, 8'h00, 32'h0000_2003);
    apb(1'b1, 8'h04, 32'h0000_2002);
    repeat (2) begin
      apb(1'b1, 8'h14, 32'h0000_FFFF);
      i_pins.pulse(1, 2, 2);
    end
    apb(1'b0, 8'h10, 32'h0);
    `CHK(rdv inside {[1:2]}, 1'b1)
    // Core timer B counting down, aux B counting up chained on core B wraps
    apb(1'b1, 8'h28, 32'h0000_0001);
    apb(1'b1, 8'h2C, 32'h0);
    apb(1'b1, 8'h24, 32'h0000_0202);
    apb(1'b1, 8'h20, 32'h0000_0201);
    repeat (40) @(posedge clk_sys);
    apb(1'b1, 8'h20, 32'h0);
    apb(1'b0, 8'h28, 32'h0);
    `CHK(rdv inside {[32'h0000_FFF0:32'h0000_FFFF]}, 1'b1)
    apb(1'b0, 8'h2C, 32'h0);
    `CHK(rdv, 32'h0000_0001)
    // Both aux timers reload core A on opposite latch edges: 4 and 2 ticks
    apb(1'b1, 8'h10, 32'h0000_FFFC);
    apb(1'b1, 8'h18, 32'h0000_FFFE);
    apb(1'b1, 8'h14, 32'h0000_FFFE);
    apb(1'b1, 8'h00, 32'h0000_0140);
    apb(1'b1, 8'h08, 32'h0000_0040);
    apb(1'b1, 8'h04, 32'h0000_2200);
    repeat (100) @(posedge clk_sys);
    hi_cnt = 0;
    repeat (60 * G1_MIN_DIV) begin
      @(posedge clk_sys);
      if (tgl === 1'b1) hi_cnt++;
    end
    `CHK(hi_cnt, 40 * G1_MIN_DIV)
    tally_and_finish();
  end
endmodule

// ==== logic/gpt_pkg.sv ====
// Constants, field layouts and types of the two general purpose timer groups
// Function
// - Each first-group timer selects timer, gated timer or counter mode independently.
// - Timer mode counts prescaled CPU clock; counter mode counts pin input events.
// - First-group finest count period is 500 ns at 16 MHz CPU clock.
// - Gated timer mode counts only while the gate pin level enables it.
// - Each first-group timer owns one pin input, used as gate or count input.
// - Software sets count direction; the direction pin may alter it dynamically.
// - Core timer A toggle latch inverts on every wrap and drives a pin.
// - Core timer A toggle latch may clock either auxiliary timer.
// - An auxiliary timer used as capture or reload register stops counting.
// - Capture: aux pin input event copies core timer A value into the aux timer.
// - Reload: core timer A loads from aux timer on pin or toggle transition.
// - Both aux timers reloading on opposite toggle transitions yield continuous PWM.
// - Timers run independently or chained within their own group only.
// - Second-group timers count prescaled CPU clock, finest period 250 ns at 16 MHz.
// - Software sets the count direction of each second-group timer.
// - Core timer B toggle latch inverts on wrap and may clock aux timer B.
// - Core timer B wrap may reload it from the capture/reload register.
// - Capture pin transition copies aux timer B into capture register, optional clear.
// - Each timer and the capture register has request flag, enable and priority.
package gpt_pkg;

  localparam int TMR_W = 16;
  localparam int PSC_W = 11;
  localparam int NUM_IRQ = 6;

  // Count resolution figures, referred to the CPU clock
  localparam int REF_CPU_MHZ = 16;
  localparam int G1_RES_NS = 500;
  localparam int G2_RES_NS = 250;
  localparam int G1_MIN_DIV = G1_RES_NS * REF_CPU_MHZ / 1000;
  localparam int G2_MIN_DIV = G2_RES_NS * REF_CPU_MHZ / 1000;
  localparam int G1_MIN_SHIFT = $clog2(G1_MIN_DIV);
  localparam int G2_MIN_SHIFT = $clog2(G2_MIN_DIV);

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL_AUX_LO = 8'h00;
  localparam logic [7:0] OFS_CTRL_CORE_A = 8'h04;
  localparam logic [7:0] OFS_CTRL_AUX_HI = 8'h08;
  localparam logic [7:0] OFS_VAL_AUX_LO = 8'h10;
  localparam logic [7:0] OFS_VAL_CORE_A = 8'h14;
  localparam logic [7:0] OFS_VAL_AUX_HI = 8'h18;
  localparam logic [7:0] OFS_CTRL_CORE_B = 8'h20;
  localparam logic [7:0] OFS_CTRL_AUX_B = 8'h24;
  localparam logic [7:0] OFS_VAL_CORE_B = 8'h28;
  localparam logic [7:0] OFS_VAL_AUX_B = 8'h2C;
  localparam logic [7:0] OFS_CAP_RELOAD = 8'h30;
  localparam logic [7:0] OFS_IRQ_FLAG = 8'h34;
  localparam logic [7:0] OFS_IRQ_EN = 8'h38;
  localparam logic [7:0] OFS_IRQ_PRIO = 8'h3C;

  // Interrupt source positions
  localparam int IRQ_AUX_LO = 0;
  localparam int IRQ_CORE_A = 1;
  localparam int IRQ_AUX_HI = 2;
  localparam int IRQ_AUX_B = 3;
  localparam int IRQ_CORE_B = 4;
  localparam int IRQ_CAPREG = 5;

  typedef enum logic [1:0] {MODE_TIMER, MODE_GATED, MODE_COUNTER, MODE_CHAIN} mode_t;
  typedef enum logic [1:0] {SPEC_NONE, SPEC_CAPTURE, SPEC_RELOAD, SPEC_RSVD} spec_t;
  typedef enum logic [1:0] {EDGE_RISE, EDGE_FALL, EDGE_BOTH, EDGE_ANY} edge_t;

  // First-group control word, bit 0 is mode[0]
  typedef struct packed {
    logic run;
    logic [2:0] psc;
    logic tgl_out;
    logic rl_rise;
    logic rl_pin;
    spec_t spec;
    logic ext_dir;
    logic down;
    logic gate_hi;
    mode_t mode;
  } g1_ctrl_t;

  // Second-group control word, bit 0 is down
  typedef struct packed {
    logic run;
    logic [2:0] psc;
    logic clr_on_cap;
    edge_t cap_edge;
    logic reload_en;
    logic chain;
    logic down;
  } g2_ctrl_t;

  localparam int G1_CTRL_W = $bits(g1_ctrl_t);
  localparam int G2_CTRL_W = $bits(g2_ctrl_t);
  localparam g1_ctrl_t G1_CTRL_RST = g1_ctrl_t'(14'h0000);
  localparam g2_ctrl_t G2_CTRL_RST = g2_ctrl_t'(10'h000);
  localparam logic [TMR_W-1:0] TMR_RST = 16'h0000;
  localparam logic [TMR_W-1:0] TMR_MAX = 16'hFFFF;

endpackage

// ==== logic/gpt_units.sv ====
// Two general purpose timer groups with an APB register slave
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/100ps
module gpt_units (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Timer pins: index 0 aux lo, 1 core A, 2 aux hi
  input wire logic [2:0] i_timer_pin_input,
  input wire logic [2:0] i_direction_pin_input,
  input wire logic i_capture_pin_input,
  // Outputs
  output logic o_toggle_pin_output,
  output logic [gpt_pkg::NUM_IRQ-1:0] o_irq_req
);
  import gpt_pkg::*;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_reset_n);

  g1_ctrl_t ctl [3];
  g2_ctrl_t ctl_b [2];
  logic [PSC_W-1:0] psc;
  logic [2:0] pin_q;
  logic cap_q;
  logic core_a_toggle_latch;
  logic core_b_toggle_latch;
  logic [TMR_W-1:0] capture_reload_reg;
  logic [NUM_IRQ-1:0] irq_flag;
  logic [NUM_IRQ-1:0] irq_en;
  logic [4*NUM_IRQ-1:0] irq_prio;
  logic [TMR_W-1:0] val [3];
  logic [TMR_W-1:0] val_b [2];
  logic [TMR_W-1:0] ld_val [3];
  logic [TMR_W-1:0] ld_val_b [2];
  logic [2:0] wrap, cnt_ev, up, ld_en, pin_rise, sw_wr;
  logic [1:0] wrap_b, cnt_ev_b, ld_en_b, sw_wr_b;
  logic tl_rise, tl_fall, tl_b_edge, cap_ev_b, cap_lo, cap_hi, rl_lo, rl_hi;
  logic wr_acc, rd_hit;
  logic [31:0] rd_data;

  // Tick of the prescaler divided by two to the k
  function automatic logic div_tick(input logic [PSC_W-1:0] cnt, input logic [3:0] k);
    logic [PSC_W-1:0] m;
    m = PSC_W'((12'd1 << k) - 12'd1);
    return (cnt & m) == m;
  endfunction

  // Shared free-running prescaler of the CPU clock
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      psc <= '0;
    end else begin
      psc <= psc + 1'b1;
    end
  end

  // Previous pin levels for edge detection
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_q <= '0;
      cap_q <= 1'b0;
    end else begin
      pin_q <= i_timer_pin_input;
      cap_q <= i_capture_pin_input;
    end
  end

  assign pin_rise = i_timer_pin_input & ~pin_q;
  assign tl_rise = wrap[1] & ~core_a_toggle_latch;
  assign tl_fall = wrap[1] & core_a_toggle_latch;
  assign wr_acc = i_psel & i_penable & o_pready & i_pwrite;

  // First group: count event, direction and counter per timer
  for (genvar i = 0; i < 3; i++) begin : g_grp1
    logic tick;
    logic gate_ok;
    assign tick = ctl[i].run &&
                  div_tick(psc, 4'(G1_MIN_SHIFT) + {1'b0, ctl[i].psc});
    assign gate_ok = i_timer_pin_input[i] == ctl[i].gate_hi;
    always_comb begin
      case (ctl[i].mode)
        MODE_TIMER: cnt_ev[i] = tick;
        MODE_GATED: cnt_ev[i] = tick && gate_ok;
        MODE_COUNTER: cnt_ev[i] = ctl[i].run && pin_rise[i];
        default: cnt_ev[i] = ctl[i].run && i != 1 && wrap[1];
      endcase
      if (i != 1 && ctl[i].spec != SPEC_NONE) begin
        cnt_ev[i] = 1'b0;
      end
    end
    assign up[i] = ~(ctl[i].down ^ (ctl[i].ext_dir & i_direction_pin_input[i]));
    assign sw_wr[i] = wr_acc && i_paddr == OFS_VAL_AUX_LO + 8'(4 * i);
    timer_cell #(.W(TMR_W)) u_cell (
      .i_clk_sys(i_clk_sys),
      .i_reset_n(i_reset_n),
      .i_count(cnt_ev[i]),
      .i_up(up[i]),
      .i_load(ld_en[i]),
      .i_load_val(ld_val[i]),
      .o_value(val[i]),
      .o_wrap(wrap[i])
    );
  end

  // Capture and reload between core timer A and the aux timers
  assign cap_lo = ctl[0].spec == SPEC_CAPTURE && pin_rise[0];
  assign cap_hi = ctl[2].spec == SPEC_CAPTURE && pin_rise[2];
  assign rl_lo = ctl[0].spec == SPEC_RELOAD &&
                 (ctl[0].rl_pin ? pin_rise[0] : (ctl[0].rl_rise ? tl_rise : tl_fall));
  assign rl_hi = ctl[2].spec == SPEC_RELOAD &&
                 (ctl[2].rl_pin ? pin_rise[2] : (ctl[2].rl_rise ? tl_rise : tl_fall));

  always_comb begin
    ld_en = sw_wr;
    ld_val[0] = i_pwdata[TMR_W-1:0];
    ld_val[1] = i_pwdata[TMR_W-1:0];
    ld_val[2] = i_pwdata[TMR_W-1:0];
    if (!sw_wr[0] && cap_lo) begin
      ld_en[0] = 1'b1;
      ld_val[0] = val[1];
    end
    if (!sw_wr[2] && cap_hi) begin
      ld_en[2] = 1'b1;
      ld_val[2] = val[1];
    end
    // Alternating reload from both aux timers forms the PWM phases
    if (!sw_wr[1] && rl_lo) begin
      ld_en[1] = 1'b1;
      ld_val[1] = val[0];
    end else if (!sw_wr[1] && rl_hi) begin
      ld_en[1] = 1'b1;
      ld_val[1] = val[2];
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      core_a_toggle_latch <= 1'b0;
    end else if (wrap[1]) begin
      core_a_toggle_latch <= ~core_a_toggle_latch;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_toggle_pin_output <= 1'b0;
    end else begin
      o_toggle_pin_output <= ctl[1].tgl_out & core_a_toggle_latch;
    end
  end

  // Second group: index 0 aux timer B, 1 core timer B
  assign tl_b_edge = wrap_b[1];
  for (genvar j = 0; j < 2; j++) begin : g_grp2
    logic tick;
    assign tick = ctl_b[j].run &&
                  div_tick(psc, 4'(G2_MIN_SHIFT) + {1'b0, ctl_b[j].psc});
    assign cnt_ev_b[j] = (j == 0 && ctl_b[j].chain) ? ctl_b[j].run && tl_b_edge : tick;
    assign sw_wr_b[j] = wr_acc && i_paddr == OFS_VAL_AUX_B - 8'(4 * j);
    timer_cell #(.W(TMR_W)) u_cell (
      .i_clk_sys(i_clk_sys),
      .i_reset_n(i_reset_n),
      .i_count(cnt_ev_b[j]),
      .i_up(~ctl_b[j].down),
      .i_load(ld_en_b[j]),
      .i_load_val(ld_val_b[j]),
      .o_value(val_b[j]),
      .o_wrap(wrap_b[j])
    );
  end

  always_comb begin
    case (ctl_b[0].cap_edge)
      EDGE_RISE: cap_ev_b = i_capture_pin_input & ~cap_q;
      EDGE_FALL: cap_ev_b = ~i_capture_pin_input & cap_q;
      default: cap_ev_b = i_capture_pin_input ^ cap_q;
    endcase
  end

  always_comb begin
    ld_en_b = sw_wr_b;
    ld_val_b[0] = i_pwdata[TMR_W-1:0];
    ld_val_b[1] = i_pwdata[TMR_W-1:0];
    if (!sw_wr_b[0] && cap_ev_b && ctl_b[0].clr_on_cap) begin
      ld_en_b[0] = 1'b1;
      ld_val_b[0] = TMR_RST;
    end
    if (!sw_wr_b[1] && wrap_b[1] && ctl_b[1].reload_en) begin
      ld_en_b[1] = 1'b1;
      ld_val_b[1] = capture_reload_reg;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      core_b_toggle_latch <= 1'b0;
    end else if (wrap_b[1]) begin
      core_b_toggle_latch <= ~core_b_toggle_latch;
    end
  end

  // Capture wins over a software write in the same cycle
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      capture_reload_reg <= TMR_RST;
    end else if (cap_ev_b) begin
      capture_reload_reg <= val_b[0];
    end else if (wr_acc && i_paddr == OFS_CAP_RELOAD) begin
      capture_reload_reg <= i_pwdata[TMR_W-1:0];
    end
  end

  // Request flags: set by events, cleared by writing ones, set wins
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_flag <= '0;
    end else begin
      irq_flag <= (irq_flag & ~((wr_acc && i_paddr == OFS_IRQ_FLAG) ?
                   i_pwdata[NUM_IRQ-1:0] : '0)) |
                  {cap_ev_b, wrap_b[1], wrap_b[0] | cap_ev_b,
                   wrap[2] | cap_hi, wrap[1], wrap[0] | cap_lo};
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_irq_req <= '0;
    end else begin
      o_irq_req <= irq_flag & irq_en;
    end
  end

  // Control registers
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctl[0] <= G1_CTRL_RST;
      ctl[1] <= G1_CTRL_RST;
      ctl[2] <= G1_CTRL_RST;
      ctl_b[0] <= G2_CTRL_RST;
      ctl_b[1] <= G2_CTRL_RST;
      irq_en <= '0;
      irq_prio <= '0;
    end else if (wr_acc) begin
      if (i_paddr == OFS_CTRL_AUX_LO) begin
        ctl[0] <= g1_ctrl_t'(i_pwdata[G1_CTRL_W-1:0]);
      end else if (i_paddr == OFS_CTRL_CORE_A) begin
        ctl[1] <= g1_ctrl_t'(i_pwdata[G1_CTRL_W-1:0]);
      end else if (i_paddr == OFS_CTRL_AUX_HI) begin
        ctl[2] <= g1_ctrl_t'(i_pwdata[G1_CTRL_W-1:0]);
      end else if (i_paddr == OFS_CTRL_AUX_B) begin
        ctl_b[0] <= g2_ctrl_t'(i_pwdata[G2_CTRL_W-1:0]);
      end else if (i_paddr == OFS_CTRL_CORE_B) begin
        ctl_b[1] <= g2_ctrl_t'(i_pwdata[G2_CTRL_W-1:0]);
      end else if (i_paddr == OFS_IRQ_EN) begin
        irq_en <= i_pwdata[NUM_IRQ-1:0];
      end else if (i_paddr == OFS_IRQ_PRIO) begin
        irq_prio <= i_pwdata[4*NUM_IRQ-1:0];
      end
    end
  end

  // Read decode
  always_comb begin
    rd_hit = 1'b1;
    rd_data = '0;
    if (i_paddr == OFS_CTRL_AUX_LO) begin
      rd_data = 32'(ctl[0]);
    end else if (i_paddr == OFS_CTRL_CORE_A) begin
      rd_data = 32'({core_a_toggle_latch, ctl[1]}) << 0;
    end else if (i_paddr == OFS_CTRL_AUX_HI) begin
      rd_data = 32'(ctl[2]);
    end else if (i_paddr == OFS_VAL_AUX_LO) begin
      rd_data = 32'(val[0]);
    end else if (i_paddr == OFS_VAL_CORE_A) begin
      rd_data = 32'(val[1]);
    end else if (i_paddr == OFS_VAL_AUX_HI) begin
      rd_data = 32'(val[2]);
    end else if (i_paddr == OFS_CTRL_CORE_B) begin
      rd_data = 32'({core_b_toggle_latch, ctl_b[1]});
    end else if (i_paddr == OFS_CTRL_AUX_B) begin
      rd_data = 32'(ctl_b[0]);
    end else if (i_paddr == OFS_VAL_CORE_B) begin
      rd_data = 32'(val_b[1]);
    end else if (i_paddr == OFS_VAL_AUX_B) begin
      rd_data = 32'(val_b[0]);
    end else if (i_paddr == OFS_CAP_RELOAD) begin
      rd_data = 32'(capture_reload_reg);
    end else if (i_paddr == OFS_IRQ_FLAG) begin
      rd_data = 32'(irq_flag);
    end else if (i_paddr == OFS_IRQ_EN) begin
      rd_data = 32'(irq_en);
    end else if (i_paddr == OFS_IRQ_PRIO) begin
      rd_data = 32'(irq_prio);
    end else begin
      rd_hit = 1'b0;
    end
  end

  // One wait state: ready in the second access cycle
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= '0;
    end else begin
      o_pready <= i_psel & i_penable & ~o_pready;
      o_pslverr <= i_psel & i_penable & ~o_pready & ~rd_hit;
      if (i_psel && i_penable && !o_pready && !i_pwrite) begin
        o_prdata <= rd_data;
      end
    end
  end

  // Checks
  a_toggle_on_wrap: assert property (
    wrap[1] |=> core_a_toggle_latch != $past(core_a_toggle_latch))
    else $error("toggle latch A did not invert on wrap");
  a_aux_stopped: assert property ((ctl[0].spec != SPEC_NONE && !ld_en[0])
    |=> $stable(val[0]))
    else $error("aux lo counted while capture or reload");
  a_capture_copy: assert property ((cap_lo && !sw_wr[0]) |=> val[0] == $past(val[1]))
    else $error("capture did not copy core A");
  a_reload_core: assert property ((rl_lo && !sw_wr[1]) |=> val[1] == $past(val[0]))
    else $error("core A not reloaded from aux lo");
  a_wrap_up: assert property ((cnt_ev[1] && up[1] && val[1] == TMR_MAX && !ld_en[1])
    |=> val[1] == TMR_RST && wrap[1])
    else $error("core A overflow wrong");
  // A switch to counter mode may count a pin edge at once
  a_min_period: assert property ((cnt_ev[1] && ctl[1].mode == MODE_TIMER &&
    ctl[1].psc == 3'd0 && $stable(ctl[1])) |=> (!cnt_ev[1] || ctl[1].mode == MODE_COUNTER) [*7])
    else $error("core A counted faster than finest period");
  a_gate_blocks: assert property ((ctl[1].mode == MODE_GATED &&
    i_timer_pin_input[1] != ctl[1].gate_hi) |-> !cnt_ev[1])
    else $error("gated timer counted with gate closed");
  a_core_b_reload: assert property ((wrap_b[1] && ctl_b[1].reload_en && !sw_wr_b[1])
    |=> val_b[1] == $past(capture_reload_reg))
    else $error("core B not reloaded");
  a_capreg_copy: assert property (cap_ev_b |=> capture_reload_reg == $past(val_b[0]) &&
    (!$past(ctl_b[0].clr_on_cap) || $past(sw_wr_b[0]) || val_b[0] == TMR_RST))
    else $error("capture register or clear wrong");
  a_flag_set: assert property (wrap[1] |=> irq_flag[IRQ_CORE_A] ##1
    (o_irq_req[IRQ_CORE_A] == irq_en[IRQ_CORE_A] || $past(wr_acc)))
    else $error("core A request flag not set");

  c_pwm_reload: cover property (rl_lo ##[1:1000] rl_hi);
  c_capture_b: cover property (cap_ev_b && ctl_b[0].clr_on_cap);
  c_toggle_out: cover property ($rose(o_toggle_pin_output));

endmodule

// ==== logic/timer_cell.sv ====
// One up/down counter with load and wrap pulse
`timescale 1ns/100ps
module timer_cell #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // Control
  input wire logic i_count,
  input wire logic i_up,
  input wire logic i_load,
  input wire logic [W-1:0] i_load_val,
  // State
  output logic [W-1:0] o_value,
  output logic o_wrap
);

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_value <= '0;
    end else if (i_load) begin
      o_value <= i_load_val;
    end else if (i_count) begin
      o_value <= i_up ? o_value + 1'b1 : o_value - 1'b1;
    end
  end

  // Overflow at all ones going up, underflow at zero going down
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_wrap <= 1'b0;
    end else begin
      o_wrap <= !i_load && i_count && (i_up ? &o_value : ~|o_value);
    end
  end

endmodule
